/* sim/cocr_host_model.sv */
// host-side model: card clock and condition queries
`timescale 1ns/1ps
`default_nettype none
module cocr_host_model (
    // link outputs
    output logic             sdClk,
    output logic             queryStb,
    output logic             queryS18Req,
    // link inputs
    input  wire logic        replyValid,
    input  wire logic [31:0] replyCond
);
    // host keeps the card clock running; offset keeps phase unrelated
    initial begin
        {sdClk, queryStb, queryS18Req} = 3'h0;
        #37;
        forever #80 sdClk = ~sdClk;
    end
    // one query; ok stays low when no reply comes
    task automatic query(input logic s18, output logic [31:0] word, output logic ok);
        int n;
        n = 0;
        @(posedge sdClk);
        queryStb    <= 1'b1;
        queryS18Req <= s18;
        @(posedge sdClk);
        queryStb    <= 1'b0;
        queryS18Req <= ~s18;
        // reply looked at mid-cycle, where the one-cycle pulse has settled
        do begin
            @(negedge sdClk);
            n++;
        end while (replyValid !== 1'b1 && n < 20);
        ok   = (replyValid === 1'b1);
        word = replyCond;
    endtask : query
endmodule : cocr_host_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the operating-condition register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin nMismatch++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
    logic             clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ok;
    logic [7:0]       awaddr, araddr, a;
    logic [31:0]      wdata, d, v;
    logic [3:0]       wstrb;
    logic [1:0]       r;
    wire logic        awready, wready, bvalid, arready, rvalid;
    wire logic        sdClk, queryStb, queryS18Req, replyValid;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata, replyCond;
    int               nMismatch = 0;
    int               checksDone = 0;
    localparam logic [31:0] IDLE_WORD = 32'h00FF8000;
    localparam logic [7:0]  MEM_ADDR [0:7] = '{8'h80, 8'h8C, 8'h90, 8'h9C,
                                               8'hA0, 8'hA4, 8'hA8, 8'hFC};
    cocr_regs #(.PWRUP_CYCLES(8)) u_dut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sdClk(sdClk),
        .queryStb(queryStb), .queryS18Req(queryS18Req), .replyValid(replyValid),
        .replyCond(replyCond));
    cocr_host_model u_host (.sdClk(sdClk), .queryStb(queryStb),
        .queryS18Req(queryS18Req), .replyValid(replyValid), .replyCond(replyCond));
    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finalReport
    task automatic limit(input logic done);
        if (!done) begin
            nMismatch++;
            $display("mismatch handshake expected answer seen timeout");
            finalReport();
        end
    endtask : limit
    task automatic axiWrite(input logic [7:0] ad, input logic [31:0] dv, output logic [1:0] rs);
        int   n;
        logic awGo, wGo, bGo;
        {n, awGo, wGo, bGo} = '0;
        @(posedge clk);
        {awaddr, wdata, wstrb} <= {ad, dv, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        // ready seen mid-cycle, the transfer happens at the next rising edge
        do begin
            @(negedge clk);
            awGo = awvalid && (awready === 1'b1);
            wGo  = wvalid && (wready === 1'b1);
            bGo  = (bvalid === 1'b1);
            rs   = bresp;
            @(posedge clk);
            n++;
            if (awGo) awvalid <= 1'b0;
            if (wGo) wvalid <= 1'b0;
        end while (!bGo && n < 100);
        bready <= 1'b0;
        limit(bGo);
    endtask : axiWrite
    task automatic axiRead(input logic [7:0] ad, output logic [31:0] dv, output logic [1:0] rs);
        int   n;
        logic arGo, rGo;
        {n, arGo, rGo} = '0;
        @(posedge clk);
        araddr <= ad;
        {arvalid, rready} <= 2'h3;
        do begin
            @(negedge clk);
            arGo = arvalid && (arready === 1'b1);
            rGo  = (rvalid === 1'b1);
            {dv, rs} = {rdata, rresp};
            @(posedge clk);
            n++;
            if (arGo) arvalid <= 1'b0;
        end while (!rGo && n < 100);
        rready <= 1'b0;
        limit(rGo);
    endtask : axiRead
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        axiRead(8'h00, d, r);
        `CHK("cond after reset", {IDLE_WORD, 2'h0}, {d, r})
        u_host.query(1'b1, d, ok);
        `CHK("busy reply", {1'b1, IDLE_WORD}, {ok, d})
        axiRead(8'h08, d, r);
        `CHK("status busy", {32'h00000101, 2'h0}, {d, r})
        axiWrite(8'h00, 32'hFFFFFFFF, r);
        `CHK("cond write refused", 2'h2, r)
        axiWrite(8'h0C, 32'h0000FFFF, r);
        `CHK("driver slot write", 2'h2, r)
        axiRead(8'h0C, d, r);
        `CHK("driver slot read", {32'h0, 2'h2}, {d, r})
        $display("test refusals done");
        // power-up count elapsed, init still pending
        repeat (20) @(posedge clk);
        axiRead(8'h00, d, r);
        `CHK("cond before init", IDLE_WORD, d)
        axiWrite(8'h04, 32'h00000003, r);
        `CHK("control write", 2'h0, r)
        d = '0;
        for (int i = 0; i < 10 && d[31] !== 1'b1; i++) u_host.query(1'b1, d, ok);
        `CHK("ready reply", 32'h81FF8000, d)
        axiRead(8'h00, d, r);
        `CHK("cond ready", 32'h81FF8000, d)
        axiRead(8'h08, d, r);
        `CHK("status ready", 32'h00000202, d)
        axiWrite(8'h04, 32'h00000007, r);
        axiRead(8'h04, d, r);
        `CHK("control readback", {32'h00000007, 2'h0}, {d, r})
        axiRead(8'h00, d, r);
        `CHK("cond capacity", 32'hC1FF8000, d)
        $display("test power-up done");
        foreach (MEM_ADDR[i]) begin
            a = MEM_ADDR[i];
            v = {24'hC3A55A, a};
            axiWrite(a, v, r);
            `CHK("storage write", 2'h0, r)
            axiRead(a, d, r);
            `CHK("storage read", (a == 8'hA8) ? {16'h0, v[15:0]} : v, d)
        end
        axiRead(8'hAC, d, r);
        `CHK("storage gap", 2'h2, r)
        $display("test storage done");
        finalReport();
    end
endmodule : testbench
`default_nettype wire

/* verilog/cocr_defines.svh */
// constants for the card operating-condition register bank
`ifndef COCR_DEFINES_SVH
`define COCR_DEFINES_SVH

// ---------------------------------------------------------------
// operating-condition word layout
// ---------------------------------------------------------------
`define COCR_COND_WIDTH    32
`define COCR_BUSY_BIT      31
`define COCR_CCS_BIT       30
`define COCR_RSVD_HI_MSB   29
`define COCR_RSVD_HI_LSB   25
`define COCR_LVACC_BIT     24
`define COCR_WIN_MSB       23
`define COCR_WIN_LSB       15
`define COCR_WIN_ONES      9'h1FF
`define COCR_RSVD_LO_MSB   14
`define COCR_RSVD_LO_ZERO  15'h0000
`define COCR_RSVD_HI_ZERO  5'h00

// ---------------------------------------------------------------
// bus map (byte addresses; storage entries as word indices)
// ---------------------------------------------------------------
`define COCR_ADDR_COND     8'h00
`define COCR_ADDR_CTRL     8'h04
`define COCR_ADDR_STAT     8'h08
`define COCR_ADDR_DRV      8'h0C
`define COCR_MEM_SEL_BIT   7
`define COCR_IDX_IDENT     5'h00
`define COCR_IDX_SPEC      5'h04
`define COCR_IDX_CONF      5'h08
`define COCR_IDX_ADDR_REG  5'h0A
`define COCR_IDX_GAP       5'h0B
`define COCR_IDX_SSR       5'h10
`define COCR_MEM_WORDS     32
`define COCR_ADDR_REG_WIDTH 16
`define COCR_RESP_OKAY     2'h0
`define COCR_RESP_SLVERR   2'h2

// ---------------------------------------------------------------
// control and status fields
// ---------------------------------------------------------------
`define COCR_CTRL_INIT_BIT 0
`define COCR_CTRL_LV_BIT   1
`define COCR_CTRL_CCS_BIT  2
`define COCR_STAT_BUSY_BIT 0
`define COCR_STAT_S18_BIT  1
`define COCR_STAT_CNT_LSB  8
`define COCR_STAT_CNT_MSB  15

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define COCR_CLK_MHZ       10
`define COCR_PWRUP_TIME_US 1000

`endif

/* verilog/cocr_link_side.sv */
// link-clock side: takes condition queries, returns the condition word
`timescale 1ns/1ps
`default_nettype none
module cocr_link_side (
    // link clock and reset
    input  wire logic        sdClk,
    input  wire logic        rst_n,
    // query from the command decoder on the link clock
    input  wire logic        queryStb,
    input  wire logic        queryS18Req,
    output logic             replyValid,
    output logic [31:0]      replyCond,
    // crossing to the core domain
    output logic             reqToggle,
    output logic             reqS18,
    input  wire logic        ackToggle,
    input  wire logic [31:0] condHold
);
    logic [1:0] rstPipe_r;
    logic [1:0] ackSync_r;
    logic       ackSeen_r;
    logic       arm_r;
    logic       pending_r;
    logic       reqToggle_r;
    logic       reqS18_r;
    logic       replyValid_r;
    logic [31:0] replyCond_r;
    wire        linkRstN = rstPipe_r[1];
    wire        ackEvent = ackSync_r[1] ^ ackSeen_r;
    wire        takeQuery = queryStb && !arm_r && !pending_r;

    assign reqToggle  = reqToggle_r;
    assign reqS18     = reqS18_r;
    assign replyValid = replyValid_r;
    assign replyCond  = replyCond_r;

    always_ff @(posedge sdClk or negedge rst_n) begin
        if (!rst_n) rstPipe_r <= 2'h0;
        else        rstPipe_r <= {rstPipe_r[0], 1'b1};
    end

    always_ff @(posedge sdClk or negedge linkRstN) begin
        if (!linkRstN) ackSync_r <= 2'h0;
        else           ackSync_r <= {ackSync_r[0], ackToggle};
    end

    // request bit settles one link cycle before the toggle moves
    always_ff @(posedge sdClk or negedge linkRstN) begin
        if (!linkRstN) begin
            arm_r       <= 1'b0;
            pending_r   <= 1'b0;
            reqToggle_r <= 1'b0;
            reqS18_r    <= 1'b0;
            ackSeen_r   <= 1'b0;
        end else begin
            ackSeen_r <= ackSync_r[1];
            if (takeQuery) begin
                reqS18_r <= queryS18Req;
                arm_r    <= 1'b1;
            end else if (arm_r) begin
                reqToggle_r <= ~reqToggle_r;
                arm_r       <= 1'b0;
                pending_r   <= 1'b1;
            end else if (ackEvent) begin
                pending_r <= 1'b0;
            end
        end
    end

    // the host keeps polling until bit 31 of this word reads 1
    always_ff @(posedge sdClk or negedge linkRstN) begin
        if (!linkRstN) begin
            replyValid_r <= 1'b0;
            replyCond_r  <= 32'h0000_0000;
        end else begin
            replyValid_r <= ackEvent && pending_r;
            if (ackEvent && pending_r) replyCond_r <= condHold;
        end
    end
endmodule : cocr_link_side
`default_nettype wire

/* verilog/cocr_pkg.sv */
// types shared by the operating-condition register bank
package cocr_pkg;
    typedef enum logic [1:0] {
        PWR_RAMP      = 2'b00,
        PWR_WAIT_INIT = 2'b01,
        PWR_READY     = 2'b10
    } cocr_pwr_type;
endpackage : cocr_pkg

/* verilog/cocr_regs.sv */
// card operating-condition register bank with AXI4-Lite access
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cocr_defines.svh"
module cocr_regs #(
    parameter int PWRUP_CYCLES = `COCR_PWRUP_TIME_US * `COCR_CLK_MHZ
) (
    // system clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // link side
    input  wire logic        sdClk,
    input  wire logic        queryStb,
    input  wire logic        queryS18Req,
    output logic             replyValid,
    output logic [31:0]      replyCond
);
    localparam int CW = $clog2(PWRUP_CYCLES + 1);
    localparam logic [CW-1:0] RAMP_LAST = CW'(PWRUP_CYCLES - 1);

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic [1:0] rstPipe_r;
    wire        rstSyncN = rstPipe_r[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rstPipe_r <= 2'h0;
        else        rstPipe_r <= {rstPipe_r[0], 1'b1};
    end

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    cocr_pkg::cocr_pwr_type pwrState_r;
    cocr_pkg::cocr_pwr_type pwrState_nxt;
    logic [CW-1:0] pwrCnt_r;
    logic          initDone_r;
    logic          lowVoltEn_r;
    logic          capacity_r;
    logic          lvAcc_r;
    logic          lvAcc_nxt;
    logic [7:0]    queryCnt_r;
    logic [31:0]   condHold_r;
    logic          ackToggle_r;
    logic [1:0]    reqSync_r;
    logic [1:0]    s18Sync_r;
    logic          reqSeen_r;
    logic [31:0]   mem_r [0:`COCR_MEM_WORDS-1];
    logic          awHeld_r;
    logic [7:0]    awAddr_r;
    logic          wHeld_r;
    logic [31:0]   wData_r;
    logic [3:0]    wStrb_r;
    logic          bvalid_r;
    logic [1:0]    bresp_r;
    logic          rvalid_r;
    logic [31:0]   rdata_r;
    logic [1:0]    rresp_r;
    logic          reqToggle;
    logic          reqS18;
    logic [31:0]   condWord;
    logic [31:0]   condNextWord;
    logic [31:0]   statWord;
    logic [31:0]   ctrlWord;
    logic [31:0]   wrMask;

    // ---------------------------------------------------------------
    // power-up and initialisation sequence
    // ---------------------------------------------------------------
    wire condDone = (pwrState_r == cocr_pkg::PWR_READY);
    wire rampEnd  = (pwrState_r == cocr_pkg::PWR_RAMP) && (pwrCnt_r == RAMP_LAST);

    always_comb begin
        pwrState_nxt = pwrState_r;
        unique case (pwrState_r)
            cocr_pkg::PWR_RAMP:      if (rampEnd) pwrState_nxt = cocr_pkg::PWR_WAIT_INIT;
            cocr_pkg::PWR_WAIT_INIT: if (initDone_r) pwrState_nxt = cocr_pkg::PWR_READY;
            cocr_pkg::PWR_READY:     pwrState_nxt = cocr_pkg::PWR_READY;
            default:                 pwrState_nxt = cocr_pkg::PWR_RAMP;
        endcase
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pwrState_r <= cocr_pkg::PWR_RAMP;
            pwrCnt_r   <= '0;
        end else begin
            pwrState_r <= pwrState_nxt;
            if (pwrState_r == cocr_pkg::PWR_RAMP && !rampEnd) pwrCnt_r <= pwrCnt_r + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // operating-condition word
    // ---------------------------------------------------------------
    // one builder shared by the bus view and the link reply
    function automatic logic [31:0] buildCond(input logic done, input logic ccs,
                                              input logic lvAcc);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`COCR_BUSY_BIT] = done;
        w[`COCR_CCS_BIT] = ccs & done;
        w[`COCR_RSVD_HI_MSB:`COCR_RSVD_HI_LSB] = `COCR_RSVD_HI_ZERO;
        w[`COCR_LVACC_BIT] = lvAcc;
        w[`COCR_WIN_MSB:`COCR_WIN_LSB] = `COCR_WIN_ONES;
        w[`COCR_RSVD_LO_MSB:0] = `COCR_RSVD_LO_ZERO;
        return w;
    endfunction : buildCond

    assign condWord     = buildCond(condDone, capacity_r, lvAcc_r);
    assign condNextWord = buildCond(condDone, capacity_r, lvAcc_nxt);

    // ---------------------------------------------------------------
    // link crossing
    // ---------------------------------------------------------------
    cocr_link_side u_link (
        .sdClk       (sdClk),
        .rst_n       (rst_n),
        .queryStb    (queryStb),
        .queryS18Req (queryS18Req),
        .replyValid  (replyValid),
        .replyCond   (replyCond),
        .reqToggle   (reqToggle),
        .reqS18      (reqS18),
        .ackToggle   (ackToggle_r),
        .condHold    (condHold_r)
    );

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            reqSync_r <= 2'h0;
            s18Sync_r <= 2'h0;
        end else begin
            reqSync_r <= {reqSync_r[0], reqToggle};
            s18Sync_r <= {s18Sync_r[0], reqS18};
        end
    end

    wire reqEvent = reqSync_r[1] ^ reqSeen_r;
    // 1.8 V only granted once ready; never withdrawn until reset
    assign lvAcc_nxt = lvAcc_r | (reqEvent & s18Sync_r[1] & lowVoltEn_r & condDone);

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            reqSeen_r   <= 1'b0;
            lvAcc_r     <= 1'b0;
            ackToggle_r <= 1'b0;
            condHold_r  <= 32'h0000_0000;
            queryCnt_r  <= 8'h00;
        end else begin
            reqSeen_r <= reqSync_r[1];
            lvAcc_r   <= lvAcc_nxt;
            if (reqEvent) begin
                condHold_r  <= condNextWord;
                ackToggle_r <= ~ackToggle_r;
                queryCnt_r  <= queryCnt_r + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    wire [4:0] wrIdx     = awAddr_r[6:2];
    wire [4:0] rdIdx     = s_axi_araddr[6:2];
    wire       wrIsMem   = awAddr_r[`COCR_MEM_SEL_BIT];
    wire       rdIsMem   = s_axi_araddr[`COCR_MEM_SEL_BIT];
    wire       wrMemOk   = wrIsMem && (wrIdx < `COCR_IDX_GAP || wrIdx >= `COCR_IDX_SSR);
    wire       rdMemOk   = rdIsMem && (rdIdx < `COCR_IDX_GAP || rdIdx >= `COCR_IDX_SSR);
    wire       wrIsCtrl  = (awAddr_r == `COCR_ADDR_CTRL);
    wire       rdIsCond  = (s_axi_araddr == `COCR_ADDR_COND);
    wire       rdIsCtrl  = (s_axi_araddr == `COCR_ADDR_CTRL);
    wire       rdIsStat  = (s_axi_araddr == `COCR_ADDR_STAT);
    wire       rdIsDrv   = (s_axi_araddr == `COCR_ADDR_DRV);
    // driver-stage slot decodes to nothing and so answers with an error
    wire       rdOk      = rdIsCond || rdIsCtrl || rdIsStat || rdMemOk;
    wire       wrOk      = wrIsCtrl || wrMemOk;
    wire       rdIsAddr  = rdIsMem && (rdIdx == `COCR_IDX_ADDR_REG);
    wire       wrIsAddr  = wrIsMem && (wrIdx == `COCR_IDX_ADDR_REG);

    assign ctrlWord = {29'h0, capacity_r, lowVoltEn_r, initDone_r};
    assign statWord = {16'h0, queryCnt_r, 6'h00, lvAcc_r, ~condDone};

    // address register keeps only 16 bits
    assign wrMask = wrIsAddr ? {{(32-`COCR_ADDR_REG_WIDTH){1'b0}}, {`COCR_ADDR_REG_WIDTH{1'b1}}}
                            : 32'hFFFF_FFFF;

    wire [31:0] rdMux = rdIsCond ? condWord :
                        rdIsCtrl ? ctrlWord :
                        rdIsStat ? statWord :
                        rdMemOk  ? mem_r[rdIdx] : 32'h0000_0000;

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
    assign s_axi_awready = !awHeld_r && !bvalid_r;
    assign s_axi_wready  = !wHeld_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHeld_r  <= 1'b0;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= `COCR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wrOk ? `COCR_RESP_OKAY : `COCR_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // control bits; only lane 0 carries them
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            initDone_r  <= 1'b0;
            lowVoltEn_r <= 1'b0;
            capacity_r  <= 1'b0;
        end else if (doWrite && wrIsCtrl && wStrb_r[0]) begin
            initDone_r  <= wData_r[`COCR_CTRL_INIT_BIT];
            lowVoltEn_r <= wData_r[`COCR_CTRL_LV_BIT];
            capacity_r  <= wData_r[`COCR_CTRL_CCS_BIT];
        end
    end

    // ---------------------------------------------------------------
    // card register storage
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `COCR_MEM_WORDS; gi++) begin : g_word
            if (gi < `COCR_IDX_GAP || gi >= `COCR_IDX_SSR) begin : g_held
                wire hit = doWrite && wrMemOk && (wrIdx == 5'(gi));
                wire [31:0] laneMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
                                        {8{wStrb_r[1]}}, {8{wStrb_r[0]}}} & wrMask;
                always_ff @(posedge clk or negedge rstSyncN) begin
                    if (!rstSyncN) mem_r[gi] <= 32'h0000_0000;
                    else if (hit)  mem_r[gi] <= (mem_r[gi] & ~laneMask) | (wData_r & laneMask);
                end
            end else begin : g_gap
                assign mem_r[gi] = 32'h0000_0000;
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `COCR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rdMux;
            rresp_r  <= rdOk ? `COCR_RESP_OKAY : `COCR_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSyncN);

    wire rdTake = s_axi_arvalid && s_axi_arready;

    AST_RSVD_ZERO: assert property (rdTake && rdIsCond |=> s_axi_rdata[29:25] == 5'h00
                                    && s_axi_rdata[14:0] == 15'h0000)
        else $error("reserved condition bits not zero");
    AST_WINDOW_ONES: assert property (rdTake && rdIsCond |=> s_axi_rdata[23:15] == 9'h1FF)
        else $error("voltage window not all ones");
    AST_BUSY_EARLY: assert property (pwrState_r != cocr_pkg::PWR_READY |-> !condWord[31])
        else $error("power-up flag set before ready");
    AST_DONE_CAUSE: assert property ($rose(condWord[31]) |-> $past(initDone_r)
                                     && $past(pwrState_r) == cocr_pkg::PWR_WAIT_INIT)
        else $error("power-up flag rose without completed init");
    AST_RAMP_BOUND: assert property (pwrState_r == cocr_pkg::PWR_RAMP |-> pwrCnt_r <= RAMP_LAST)
        else $error("ramp counter overran");
    AST_S18_NEEDS_READY: assert property ($rose(lvAcc_r) |-> condDone && $past(lowVoltEn_r))
        else $error("1.8 V accepted too early");
    AST_READ_COND: assert property (rdTake && rdIsCond |=> s_axi_rvalid
                                    && s_axi_rdata == $past(condWord))
        else $error("condition word read back wrong");
    AST_DRV_REFUSED: assert property (rdTake && rdIsDrv |=> s_axi_rresp == `COCR_RESP_SLVERR
                                      && s_axi_rdata == 32'h0000_0000)
        else $error("driver-stage slot not refused");
    AST_ADDR_WIDTH: assert property (rdTake && rdIsAddr |=> s_axi_rdata[31:16] == 16'h0000)
        else $error("address register wider than 16 bits");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    COV_READY: cover property ($rose(condDone));
    COV_S18: cover property ($rose(lvAcc_r));
    COV_QUERY: cover property (reqEvent ##1 condHold_r[31]);
    COV_DRV: cover property (rdTake && rdIsDrv);
endmodule : cocr_regs
`default_nettype wire
